// ---- rtl/atcb_bank.sv ----
// control-bus register bank with hit-bit trigger logic
// assumes the bus master issues one single-cycle read or write at a time
`default_nettype none
module atcb_bank
  import atcb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control bus
  input wire logic [15:0] cb_addr,
  input wire logic [3:0] cb_sub,
  input wire logic cb_wr,
  input wire logic cb_rd,
  input wire logic [15:0] cb_wdata,
  output logic [15:0] cb_rdata,
  // run state from status register
  input wire logic run_active,
  // processing configuration
  output logic [8:0] window_length,
  output logic [8:0] report_window_len,
  output logic [10:0] trigger_latency,
  output logic [11:0] pre_peak_count,
  output logic [12:0] post_peak_count,
  output logic [13:0] report_post_count,
  output logic [NCH-1:0][11:0] energy_threshold,
  output logic [11:0] buf_last_addr,
  output logic [7:0] max_blocks,
  output logic [1:0] hit_mode,
  output logic fifo_sel_sum,
  // test waveform and external fifo
  output logic test_pulse_wr,
  output logic [15:0] test_pulse_source,
  input wire logic [15:0] test_pulse_rdata,
  output logic fifo_rd,
  input wire logic [15:0] fifo_rdata,
  // hit bits and energy sum
  input wire logic [NCH-1:0] hit_in,
  input wire logic [15:0] channel_energy_total,
  output logic [NCH-1:0] hit_oneshot,
  output logic [15:0] backplane_output,
  output logic trig_valid,
  output logic [15:0] trig_pattern,
  output logic live_trigger_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] hit_delay_field(input logic [15:0] w);
    return w[12:8];
  endfunction

  function automatic logic [7:0] hit_oneshot_width(input logic [15:0] w);
    return w[7:0];
  endfunction

  // ------------------------------------------------------------
  // state and table memory
  // ------------------------------------------------------------
  atcb_state_t st_r;
  atcb_state_t st_nxt;
  logic table_mem [0:65535];
  logic wr_ok;
  logic table_we;
  logic table_bit;
  logic cond;
  logic [15:0] q;

  assign wr_ok = cb_wr & ~run_active;
  assign table_we = wr_ok && (cb_addr == A_TABLE);
  assign table_bit = table_mem[st_r.taddr];

  always_ff @(posedge mclk) begin
    if (table_we) begin
      table_mem[st_r.taddr] <= cb_wdata[0];
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.twave_wr = 1'b0;
    st_nxt.fifo_rd = 1'b0;
    st_nxt.trig_valid = 1'b0;
    cond = 1'b0;
    q = 16'h0000;
    // bus writes
    if (wr_ok) begin
      unique case (cb_addr)
        A_CFG3: st_nxt.cfg3 = cb_wdata[4:0];
        A_WLEN: st_nxt.wlen = cb_wdata[8:0];
        A_LAT: st_nxt.lat = cb_wdata[10:0];
        A_PRE: st_nxt.pre = cb_wdata[11:0];
        A_POST: st_nxt.post = cb_wdata[12:0];
        A_BLAST: st_nxt.blast = cb_wdata[11:0];
        A_MAXB: st_nxt.maxb = cb_wdata[7:0];
        A_TWAVE: begin
          st_nxt.twave = cb_wdata;
          st_nxt.twave_wr = 1'b1;
        end
        A_HITW: st_nxt.hitw[cb_sub] = cb_wdata;
        A_LIVEW: st_nxt.livew = cb_wdata[7:0];
        A_WMASK: st_nxt.wmask = cb_wdata;
        A_WWID: st_nxt.wwid = cb_wdata;
        A_OMASK: st_nxt.omask = cb_wdata;
        A_TABLE: st_nxt.taddr = st_r.taddr + 16'h0001;
        A_SUMTH: st_nxt.sumth = cb_wdata;
        default: begin
          if (cb_addr >= A_THR0 && cb_addr <= A_THRN) begin
            st_nxt.thr[4'(cb_addr - A_THR0)] = cb_wdata[11:0];
          end
        end
      endcase
    end
    // bus reads
    if (cb_rd) begin
      st_nxt.rdata = 16'h0000;
      unique case (cb_addr)
        A_CFG3: st_nxt.rdata = {11'h000, st_r.cfg3};
        A_WLEN: st_nxt.rdata = {7'h00, st_r.wlen};
        A_LAT: st_nxt.rdata = {5'h00, st_r.lat};
        A_PRE: st_nxt.rdata = {4'h0, st_r.pre};
        A_POST: st_nxt.rdata = {3'h0, st_r.post};
        A_BLAST: st_nxt.rdata = {4'h0, st_r.blast};
        A_MAXB: st_nxt.rdata = {8'h00, st_r.maxb};
        A_TWAVE: st_nxt.rdata = test_pulse_rdata;
        A_HITW: st_nxt.rdata = st_r.hitw[cb_sub];
        A_LIVEW: st_nxt.rdata = {8'h00, st_r.livew};
        A_WMASK: st_nxt.rdata = st_r.wmask;
        A_WWID: st_nxt.rdata = st_r.wwid;
        A_OMASK: st_nxt.rdata = st_r.omask;
        A_TABLE: begin
          if (st_r.cfg3[CFG3_RDBACK]) begin
            st_nxt.rdata = {15'h0000, table_bit};
            st_nxt.taddr = st_r.taddr + 16'h0001;
          end
        end
        A_FIFO: begin
          st_nxt.rdata = fifo_rdata;
          st_nxt.fifo_rd = 1'b1;
        end
        A_SUMTH: st_nxt.rdata = st_r.sumth;
        default: begin
          if (cb_addr >= A_THR0 && cb_addr <= A_THRN) begin
            st_nxt.rdata = {4'h0, st_r.thr[4'(cb_addr - A_THR0)]};
          end
        end
      endcase
    end
    // hit delay line and one-shots
    st_nxt.sync1 = hit_in;
    st_nxt.sync2 = st_r.sync1;
    for (int ch = 0; ch < NCH; ch++) begin
      logic tap;
      tap = 1'b0;
      st_nxt.hist[ch] = {st_r.hist[ch][HIST_W-2:0], st_r.sync2[ch]};
      tap = st_r.hist[ch][hit_delay_field(st_r.hitw[ch]) + HIT_DLY_BASE];
      st_nxt.prev_tap[ch] = tap;
      if (st_r.osact[ch]) begin
        if (st_r.oscnt[ch] == 8'h00) begin
          st_nxt.osact[ch] = 1'b0;
        end else begin
          st_nxt.oscnt[ch] = st_r.oscnt[ch] - 8'h01;
        end
      end else if (tap && !st_r.prev_tap[ch]) begin
        st_nxt.osact[ch] = 1'b1;
        st_nxt.oscnt[ch] = hit_oneshot_width(st_r.hitw[ch]);
      end
    end
    // trigger formation per mode
    unique case (st_r.cfg3[1:0])
      MODE_WINDOW: begin
        q = st_r.osact & st_r.wmask;
        unique case (st_r.win)
          WIN_IDLE: begin
            if (q != 16'h0000) begin
              st_nxt.win = WIN_OPEN;
              st_nxt.wcnt = {1'b0, st_r.wwid} + 17'h00001;
              st_nxt.pattern = q;
            end
          end
          WIN_OPEN: begin
            st_nxt.pattern = st_r.pattern | q;
            if (st_r.wcnt == 17'h00000) begin
              st_nxt.win = WIN_IDLE;
              st_nxt.trig_valid = 1'b1;
              st_nxt.trig_pat = st_r.pattern | q;
            end else begin
              st_nxt.wcnt = st_r.wcnt - 17'h00001;
            end
          end
          default: st_nxt.win = WIN_IDLE;
        endcase
      end
      MODE_OVERLAP: begin
        q = st_r.osact & st_r.omask;
        cond = (q != 16'h0000);
        st_nxt.win = WIN_IDLE;
      end
      MODE_TABLE: begin
        q = st_r.osact;
        cond = st_r.cfg3[CFG3_RDBACK] && table_mem[st_r.osact];
        st_nxt.win = WIN_IDLE;
      end
      default: begin
        st_nxt.win = WIN_IDLE;
      end
    endcase
    st_nxt.prev_cond = cond;
    if (cond && !st_r.prev_cond) begin
      st_nxt.trig_valid = 1'b1;
      st_nxt.trig_pat = q;
    end
    // live trigger pulse
    if (st_r.live) begin
      if (st_r.lcnt == 8'h00) begin
        st_nxt.live = 1'b0;
      end else begin
        st_nxt.lcnt = st_r.lcnt - 8'h01;
      end
    end else if (st_nxt.trig_valid) begin
      st_nxt.live = 1'b1;
      st_nxt.lcnt = st_r.livew;
    end
    // backplane output select
    if (st_r.cfg3[CFG3_OUT_SEL]) begin
      st_nxt.bp_out = st_r.osact;
    end else begin
      st_nxt.bp_out = {15'h0000, channel_energy_total > st_r.sumth};
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.wlen <= WLEN_MIN;
      st_r.pre <= PRE_MIN;
      st_r.win <= WIN_IDLE;
      st_r.taddr <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign cb_rdata = st_r.rdata;
  assign window_length = st_r.wlen;
  assign report_window_len = {st_r.wlen[8:1], 1'b0};
  assign trigger_latency = st_r.lat;
  assign pre_peak_count = st_r.pre;
  assign post_peak_count = st_r.post;
  assign report_post_count = {1'b0, st_r.post} +
    (st_r.post[0] ? 14'h0001 : 14'h0002);
  assign energy_threshold = st_r.thr;
  assign buf_last_addr = st_r.blast;
  assign max_blocks = st_r.maxb;
  assign hit_mode = st_r.cfg3[1:0];
  assign fifo_sel_sum = st_r.cfg3[CFG3_FIFO_SEL];
  assign test_pulse_wr = st_r.twave_wr;
  assign test_pulse_source = st_r.twave;
  assign fifo_rd = st_r.fifo_rd;
  assign hit_oneshot = st_r.osact;
  assign backplane_output = st_r.bp_out;
  assign trig_valid = st_r.trig_valid;
  assign trig_pattern = st_r.trig_pat;
  assign live_trigger_out = st_r.live;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb_clk @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_run_blocks_write: assert property (
    run_active && cb_wr && cb_addr == A_WLEN |=> $stable(window_length))
    else $error("window length changed while running");

  a_report_even: assert property (
    report_window_len[0] == 1'b0 &&
    report_window_len + {8'h00, window_length[0]} == window_length)
    else $error("reported window length not even");

  a_post_extra: assert property (
    report_post_count - {1'b0, post_peak_count} ==
    (post_peak_count[0] ? 14'h0001 : 14'h0002))
    else $error("post-peak report count wrong");

  a_oneshot_width: assert property (
    $rose(hit_oneshot[0]) && st_r.hitw[0][7:0] == 8'h03 |->
    hit_oneshot[0] [*4] ##1 !hit_oneshot[0])
    else $error("one-shot width wrong");

  a_hit_delay: assert property (
    $rose(st_r.hist[1][0]) && st_r.hitw[1][12:8] == 5'h00 &&
    $stable(st_r.hitw[1]) |-> ##5 hit_oneshot[1])
    else $error("hit delay wrong");

  a_live_width: assert property (
    $rose(live_trigger_out) && st_r.lcnt == 8'h02 |->
    live_trigger_out [*3] ##1 !live_trigger_out)
    else $error("live trigger width wrong");

  a_window_mask: assert property (
    trig_valid && hit_mode == MODE_WINDOW |->
    (trig_pattern & ~st_r.wmask) == 16'h0000)
    else $error("window pattern holds unmasked bit");

  a_window_open: assert property (
    $rose(st_r.win == WIN_OPEN) && st_r.wcnt == 17'h00002 |->
    (st_r.win == WIN_OPEN) [*3] ##1 st_r.win == WIN_IDLE)
    else $error("window open length wrong");

  a_overlap_mask: assert property (
    trig_valid && hit_mode == MODE_OVERLAP |->
    (trig_pattern & ~st_r.omask) == 16'h0000)
    else $error("overlap pattern holds unmasked bit");

  a_table_inc: assert property (
    table_we |=> st_r.taddr == $past(st_r.taddr) + 16'h0001)
    else $error("table address did not advance");

  a_out_select: assert property (
    st_r.cfg3[CFG3_OUT_SEL] && $past(st_r.cfg3[CFG3_OUT_SEL]) |->
    backplane_output == $past(st_r.osact))
    else $error("backplane output not hit bits");

  a_readback_off: assert property (
    cb_rd && cb_addr == A_TABLE && !st_r.cfg3[CFG3_RDBACK] |=>
    cb_rdata == 16'h0000)
    else $error("table read while readback off");

  a_table_reset: assert property (
    $past(rst) |-> st_r.taddr == 16'h0000)
    else $error("table address not cleared by reset");
endmodule
`default_nettype wire

// ---- pkg/atcb_pkg.sv ----
// constants, state types and offsets of the trigger config bank
// assumes a single 250 MHz-class control clock shared with the bus
`default_nettype none
package atcb_pkg;
  // ------------------------------------------------------------
  // control bus offsets
  // ------------------------------------------------------------
  localparam logic [15:0] A_CFG3 = 16'h0004;
  localparam logic [15:0] A_WLEN = 16'h0005;
  localparam logic [15:0] A_LAT = 16'h0006;
  localparam logic [15:0] A_PRE = 16'h0007;
  localparam logic [15:0] A_POST = 16'h0008;
  localparam logic [15:0] A_THR0 = 16'h0009;
  localparam logic [15:0] A_THRN = 16'h0018;
  localparam logic [15:0] A_BLAST = 16'h001a;
  localparam logic [15:0] A_MAXB = 16'h001b;
  localparam logic [15:0] A_TWAVE = 16'h001c;
  localparam logic [15:0] A_HITW = 16'h001d;
  localparam logic [15:0] A_LIVEW = 16'h001e;
  localparam logic [15:0] A_WMASK = 16'h001f;
  localparam logic [15:0] A_WWID = 16'h0020;
  localparam logic [15:0] A_OMASK = 16'h0021;
  localparam logic [15:0] A_TABLE = 16'h0022;
  localparam logic [15:0] A_FIFO = 16'h0023;
  localparam logic [15:0] A_SUMTH = 16'h0024;
  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int CFG3_FIFO_SEL = 2;
  localparam int CFG3_OUT_SEL = 3;
  localparam int CFG3_RDBACK = 4;
  localparam logic [1:0] MODE_TABLE = 2'h0;
  localparam logic [1:0] MODE_OVERLAP = 2'h1;
  localparam logic [1:0] MODE_WINDOW = 2'h2;
  localparam int NCH = 16;
  localparam int HIT_DLY_BASE = 4;
  localparam int HIST_W = 36;
  localparam logic [8:0] WLEN_MIN = 9'h006;
  localparam logic [11:0] PRE_MIN = 12'h002;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_OPEN = 2'b10
  } atcb_win_t;

  typedef struct packed {
    logic [4:0] cfg3;
    logic [8:0] wlen;
    logic [10:0] lat;
    logic [11:0] pre;
    logic [12:0] post;
    logic [NCH-1:0][11:0] thr;
    logic [11:0] blast;
    logic [7:0] maxb;
    logic [NCH-1:0][15:0] hitw;
    logic [7:0] livew;
    logic [15:0] wmask;
    logic [15:0] wwid;
    logic [15:0] omask;
    logic [15:0] sumth;
    logic [15:0] taddr;
    logic [15:0] rdata;
    logic [15:0] twave;
    logic twave_wr;
    logic fifo_rd;
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [NCH-1:0][HIST_W-1:0] hist;
    logic [NCH-1:0] prev_tap;
    logic [NCH-1:0][7:0] oscnt;
    logic [NCH-1:0] osact;
    atcb_win_t win;
    logic [16:0] wcnt;
    logic [15:0] pattern;
    logic prev_cond;
    logic [15:0] trig_pat;
    logic trig_valid;
    logic [7:0] lcnt;
    logic live;
    logic [15:0] bp_out;
  } atcb_state_t;
endpackage
`default_nettype wire

// ---- verif/atcb_host_model.sv ----
// bus master model of the control bus, with the software side sums
// assumes mclk from the bench; tasks are entered on a falling edge
`default_nettype none
module atcb_host_model (
  // clock
  input wire logic mclk,
  // control bus
  output logic [15:0] cb_addr,
  output logic [3:0] cb_sub,
  output logic cb_wr,
  output logic cb_rd,
  output logic [15:0] cb_wdata,
  input wire logic [15:0] cb_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    cb_addr = 16'h0000;
    cb_sub = 4'h0;
    cb_wr = 1'b0;
    cb_rd = 1'b0;
    cb_wdata = 16'h0000;
  end
  // write: held over one rising edge, lines scrambled, one idle cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    cb_addr = a;
    cb_wdata = d;
    cb_sub = s;
    cb_wr = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    cb_wr = 1'b0;
    cb_addr = ~a;
    cb_wdata = ~d;
    cb_sub = ~s;
    @(negedge mclk);
  endtask
  // read: data taken after the answer edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    cb_addr = a;
    cb_rd = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    cb_rd = 1'b0;
    cb_addr = ~a;
    @(posedge mclk);
    @(negedge mclk);
    d = cb_rdata;
  endtask
  // ------------------------------------------------------------
  // software sums
  // ------------------------------------------------------------
  function automatic logic [8:0] win_len(input int ns);
    return 9'(ns * 250 / 1000);
  endfunction
  function automatic logic [12:0] post_min(input logic [1:0] mode);
    return (mode == 2'h2) ? 13'h0006 : 13'h0003;
  endfunction
  function automatic logic [7:0] max_blk(input logic [8:0] wl);
    return 8'(2016 / (int'(wl) + 8));
  endfunction
  function automatic logic [11:0] last_adr(input logic [7:0] mb,
                                          input logic [8:0] wl);
    return 12'(int'(mb) * (int'(wl) + 6) - 1);
  endfunction
endmodule
`default_nettype wire

// ---- verif/atcb_bank_tb.sv ----
// self-checking bench of the trigger config bank
// assumes the host model drives the control bus on falling edges
`default_nettype none
module atcb_bank_tb
  import atcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, run_active, cb_wr, cb_rd, test_pulse_wr, fifo_rd;
  logic [15:0] cb_addr, cb_wdata, cb_rdata, test_pulse_rdata, fifo_rdata;
  logic [3:0] cb_sub;
  logic [8:0] window_length, report_window_len;
  logic [10:0] trigger_latency;
  logic [11:0] pre_peak_count, buf_last_addr;
  logic [12:0] post_peak_count;
  logic [13:0] report_post_count;
  logic [NCH-1:0][11:0] energy_threshold;
  logic [7:0] max_blocks;
  logic [1:0] hit_mode;
  logic fifo_sel_sum, trig_valid, live_trigger_out;
  logic [15:0] test_pulse_source, channel_energy_total, backplane_output;
  logic [15:0] trig_pattern;
  logic [NCH-1:0] hit_in, hit_oneshot;
  logic [15:0] wa[12], wd[12], we[12];
  logic os0 = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0, n_trig = 0, n_live = 0, n_bp = 0, t_os = 0, t_trig = 0;
  int dly, wid;
  int n_tw = 0, n_fr = 0;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  atcb_host_model host (.mclk, .cb_addr, .cb_sub, .cb_wr, .cb_rd,
    .cb_wdata, .cb_rdata);
  atcb_bank dut (.mclk, .rst, .cb_addr, .cb_sub, .cb_wr, .cb_rd,
    .cb_wdata, .cb_rdata, .run_active, .window_length,
    .report_window_len, .trigger_latency, .pre_peak_count,
    .post_peak_count, .report_post_count, .energy_threshold,
    .buf_last_addr, .max_blocks, .hit_mode, .fifo_sel_sum,
    .test_pulse_wr, .test_pulse_source, .test_pulse_rdata, .fifo_rd,
    .fifo_rdata, .hit_in, .channel_energy_total, .hit_oneshot,
    .backplane_output, .trig_valid, .trig_pattern, .live_trigger_out);
  // ------------------------------------------------------------
  // clock, watchdog, monitor
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  always @(posedge mclk) begin
    #1;
    cyc++;
    if (trig_valid === 1'b1) begin
      n_trig++;
      t_trig = cyc;
    end
    if (live_trigger_out === 1'b1) n_live++;
    if (test_pulse_wr === 1'b1) n_tw++;
    if (fifo_rd === 1'b1) n_fr++;
    if (backplane_output[0] === 1'b1) n_bp++;
    if (hit_oneshot[0] === 1'b1 && os0 !== 1'b1) t_os = cyc;
    os0 = hit_oneshot[0];
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    host.wr(a, d, 4'h0);
  endtask
  task automatic rdc(input string nm, input logic [15:0] a,
                     input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    check(nm, d, e);
  endtask
  // raise hit bits; measure delay and width of one channel's one-shot
  task automatic fire(input logic [15:0] m, input int ch);
    {n_trig, n_live, n_bp, dly, wid} = '0;
    hit_in = m;
    @(posedge mclk);
    #1;
    while (hit_oneshot[ch] !== 1'b1 && dly < 99) begin
      @(posedge mclk);
      #1;
      dly++;
    end
    while (hit_oneshot[ch] === 1'b1 && wid < 99) begin
      @(posedge mclk);
      #1;
      wid++;
    end
    @(negedge mclk);
    hit_in = '0;
    idle(12);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [8:0] wl;
    logic [7:0] mb;
    rst = 1'b1;
    run_active = 1'b0;
    hit_in = '0;
    test_pulse_rdata = 16'h5a3c;
    fifo_rdata = 16'hc3a5;
    channel_energy_total = 16'h0000;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check("rwlen", 16'(report_window_len), 16'h0006);
    check("rpost", 16'(report_post_count), 16'h0002);
    rdc("pre", A_PRE, 16'h0002);
    // table load, then reset to rewind the address
    put(A_CFG3, 16'h0010);
    put(A_TABLE, 16'h0001);
    put(A_TABLE, 16'h0000);
    put(A_TABLE, 16'h0003);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    rdc("tbl_off", A_TABLE, 16'h0000);
    put(A_CFG3, 16'h0014);
    check("fsel", 16'(fifo_sel_sum), 16'h0001);
    for (int i = 0; i < 3; i++) rdc("tbl", A_TABLE, 16'(i % 2 == 0));
    // plain registers
    wl = host.win_len(100);
    mb = host.max_blk(wl);
    wa = '{A_WLEN, A_LAT, A_PRE, A_POST, A_THRN, A_BLAST, A_MAXB,
      A_SUMTH, A_WMASK, A_OMASK, A_WWID, A_LIVEW};
    wd = '{16'(wl), 16'hffff, 16'hffff, 16'(host.post_min(2'h0) + 2),
      16'hffff, 16'(host.last_adr(mb, wl)), 16'(mb), 16'h0100,
      16'h0001, 16'h0001, 16'h0001, 16'h0002};
    we = '{16'(wl), 16'h07ff, 16'h0fff, 16'h0005, 16'h0fff,
      16'(host.last_adr(mb, wl)), 16'(mb), 16'h0100,
      16'h0001, 16'h0001, 16'h0001, 16'h0002};
    foreach (wa[i]) put(wa[i], wd[i]);
    foreach (wa[i]) rdc("reg", wa[i], we[i]);
    check("rwlen", 16'(report_window_len), 16'(wl) & 16'hfffe);
    check("lat", 16'(trigger_latency), 16'h07ff);
    check("wlen", 16'(window_length), 16'(wl));
    check("pre", 16'(pre_peak_count), 16'h0fff);
    check("post", 16'(post_peak_count), 16'h0005);
    check("thr", 16'(energy_threshold[NCH-1]), 16'h0fff);
    check("blast", 16'(buf_last_addr), 16'(host.last_adr(mb, wl)));
    check("maxb", 16'(max_blocks), 16'(mb));
    check("rpost", 16'(report_post_count), 16'h0006);
    put(A_POST, 16'h0006);
    check("rpost", 16'(report_post_count), 16'h0008);
    run_active = 1'b1;
    put(A_WLEN, 16'h0040);
    run_active = 1'b0;
    rdc("run", A_WLEN, 16'(wl));
    rdc("unmapped", 16'h0025, 16'h0000);
    rdc("fifo", A_FIFO, fifo_rdata);
    check("fifo_rd", 16'(n_fr), 16'h0001);
    put(A_TWAVE, 16'h1234);
    check("tw_wr", 16'(n_tw), 16'h0001);
    check("tw_src", test_pulse_source, 16'h1234);
    rdc("tw_rd", A_TWAVE, 16'h5a3c);
    // overlap mode, hit bits to the backplane
    put(A_CFG3, 16'h0009);
    check("mode", 16'(hit_mode), 16'(MODE_OVERLAP));
    host.wr(A_HITW, 16'h0203, 4'h0);
    fire(16'h0001, 0);
    check("dly", 16'(dly), 16'h0009);
    check("wid", 16'(wid), 16'h0004);
    check("bp", 16'(n_bp), 16'h0004);
    check("ntrig", 16'(n_trig), 16'h0001);
    check("tlat", 16'(t_trig - t_os), 16'h0001);
    check("live", 16'(n_live), 16'h0003);
    fire(16'h0002, 1);
    check("dly1", 16'(dly), 16'h0007);
    check("wid1", 16'(wid), 16'h0001);
    check("ntrig", 16'(n_trig), 16'h0000);
    // window mode
    put(A_CFG3, 16'h000a);
    fire(16'h0003, 0);
    check("ntrig", 16'(n_trig), 16'h0001);
    check("wopen", 16'(t_trig - t_os), 16'h0004);
    check("pat", trig_pattern, 16'h0001);
    fire(16'h0002, 1);
    check("ntrig", 16'(n_trig), 16'h0000);
    // sum to the backplane
    put(A_CFG3, 16'h0000);
    channel_energy_total = 16'h0101;
    idle(3);
    check("sum", backplane_output, 16'h0001);
    channel_energy_total = 16'h0100;
    idle(3);
    check("sum", backplane_output, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
